// ===== ride_through_defines.svh
`ifndef RIDE_THROUGH_DEFINES_SVH
`define RIDE_THROUGH_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_OUT1_SEL 14'h0A00
`define IDX_OUT2_SEL 14'h0A01
`define IDX_RELAY_A_SEL 14'h0A02
`define IDX_RELAY_B_SEL 14'h0A03
`define IDX_LVL_A_VAL 14'h0A14
`define IDX_LVL_A_HYST 14'h0A15
`define IDX_LVL_B_VAL 14'h0A16
`define IDX_LVL_B_HYST 14'h0A17
`define IDX_RT_MODE 14'h0D14
`define IDX_RT_DIS_LVL 14'h0D15
`define IDX_RT_EN_LVL 14'h0D16
`define IDX_RT_REC_DLY 14'h0D17
`define IDX_RT_KP 14'h0D18
`define IDX_RT_KI 14'h0D19
`define IDX_RT_DEC_TIME 14'h0D1A
`define IDX_STATUS 14'h0D1F

// reset values (percent in 0.1 %, frequency in 0.01 Hz, time in 0.1 s)
`define RST_OUT_SEL 16'h0002
`define RST_RELAY_A_SEL 16'h0008
`define RST_RELAY_B_SEL 16'h0000
`define RST_LVL_VAL 16'h01F4
`define RST_LVL_HYST 16'h0000
`define RST_RT_MODE 16'h0000
`define RST_RT_DIS_LVL 16'h0352
`define RST_RT_EN_LVL 16'h0320
`define RST_RT_REC_DLY 16'h0005
`define RST_RT_KP 16'h0032
`define RST_RT_KI 16'h001E
`define RST_RT_DEC_TIME 16'h00C8

// ride-through mode codes
`define RT_MODE_OFF 16'h0000
`define RT_MODE_HOLD 16'h0001
`define RT_MODE_STOP 16'h0002

// output function codes
`define FUNC_LVL_A 16'h000F
`define FUNC_LVL_B 16'h0010
`define FUNC_MAX 16'h0023

// full scale of a hysteresis percentage, 100.0 %
`define HYST_FULL 16'h03E8

// timing: one delay step is 0.1 s, clock period 40 ns
`define RT_STEP_MS 100
`define CLK_PERIOD_NS 40
`define RT_STEP_CYCLES (`RT_STEP_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// ===== ride_through_pkg.sv
package ride_through_pkg;

  // software settings of the block
  typedef struct packed {
    logic [3:0][15:0] out_sel;
    logic [1:0][15:0] lvl_val;
    logic [1:0][15:0] lvl_hyst;
    logic [15:0] mode;
    logic [15:0] dis_lvl;
    logic [15:0] en_lvl;
    logic [15:0] rec_dly;
    logic [15:0] kp;
    logic [15:0] ki;
    logic [15:0] dec_time;
  } cfg_t;

  // ride-through sequencer
  typedef enum logic [2:0] {
    RT_IDLE,
    RT_HOLD,
    RT_SUSPEND,
    RT_RECOVER,
    RT_DECEL,
    RT_STOPPED
  } rt_state_t;

endpackage

// ===== power_dip_and_freq_level_detect.sv
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "ride_through_defines.svh"

module power_dip_and_freq_level_detect #(
  parameter int STEP_CYCLES = `RT_STEP_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic supply_ok,
  input wire logic [15:0] bus_voltage_pct,
  input wire logic [15:0] oper_freq,
  input wire logic [15:0] maximum_output_frequency,
  input wire logic [15:0] normal_decel_time,
  input wire logic decelerating,
  input wire logic run_cmd,
  output logic regen_hold,
  output logic [15:0] rt_gain_kp,
  output logic [15:0] rt_gain_ki,
  output logic decel_to_stop,
  output logic [15:0] decel_time,
  output logic recover_accel,
  output logic uv_trip_enable,
  output logic digital_output_one,
  output logic digital_output_two,
  output logic relay_a_output,
  output logic second_relay_output
);

  ride_through_pkg::cfg_t cfg_q;
  ride_through_pkg::rt_state_t state_q, state_d;
  logic [13:0] wr_idx_q;
  logic wr_pend_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic [15:0] rd_val;
  logic [31:0] pre_q;
  logic [15:0] rec_cnt_q;
  logic run_cmd_q;
  logic regen_hold_q, decel_stop_q, recover_q, uv_en_q;
  logic [15:0] kp_q, ki_q, decel_time_q;
  logic [1:0] lvl_q;
  logic [3:0] term_q;

  // bus decode
  wire [13:0] a_idx = haddr[15:2];
  wire a_take = hsel & htrans[1] & hready;
  wire [15:0] wdat = hwdata[15:0];
  wire bypass = wr_pend_q & (wr_idx_q == a_idx);

  // register read selection
  always_comb begin
    case (a_idx)
      `IDX_OUT1_SEL: rd_val = cfg_q.out_sel[0];
      `IDX_OUT2_SEL: rd_val = cfg_q.out_sel[1];
      `IDX_RELAY_A_SEL: rd_val = cfg_q.out_sel[2];
      `IDX_RELAY_B_SEL: rd_val = cfg_q.out_sel[3];
      `IDX_LVL_A_VAL: rd_val = cfg_q.lvl_val[0];
      `IDX_LVL_A_HYST: rd_val = cfg_q.lvl_hyst[0];
      `IDX_LVL_B_VAL: rd_val = cfg_q.lvl_val[1];
      `IDX_LVL_B_HYST: rd_val = cfg_q.lvl_hyst[1];
      `IDX_RT_MODE: rd_val = cfg_q.mode;
      `IDX_RT_DIS_LVL: rd_val = cfg_q.dis_lvl;
      `IDX_RT_EN_LVL: rd_val = cfg_q.en_lvl;
      `IDX_RT_REC_DLY: rd_val = cfg_q.rec_dly;
      `IDX_RT_KP: rd_val = cfg_q.kp;
      `IDX_RT_KI: rd_val = cfg_q.ki;
      `IDX_RT_DEC_TIME: rd_val = cfg_q.dec_time;
      `IDX_STATUS: rd_val = {5'h00, term_q, lvl_q, uv_en_q, regen_hold_q,
                             state_q};
      default: rd_val = 16'h0000;
    endcase
  end

  // bus phases; zero wait states, read data set up in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 14'h0000;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      wr_pend_q <= a_take & hwrite;
      if (a_take)
        wr_idx_q <= a_idx;
      if (a_take & ~hwrite)
        hrdata_q <= {16'h0000, bypass ? wdat : rd_val};
    end
  end

  // register writes in the data phase; unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q.out_sel[0] <= `RST_OUT_SEL;
      cfg_q.out_sel[1] <= `RST_OUT_SEL;
      cfg_q.out_sel[2] <= `RST_RELAY_A_SEL;
      cfg_q.out_sel[3] <= `RST_RELAY_B_SEL;
      cfg_q.lvl_val <= {`RST_LVL_VAL, `RST_LVL_VAL};
      cfg_q.lvl_hyst <= {`RST_LVL_HYST, `RST_LVL_HYST};
      cfg_q.mode <= `RST_RT_MODE;
      cfg_q.dis_lvl <= `RST_RT_DIS_LVL;
      cfg_q.en_lvl <= `RST_RT_EN_LVL;
      cfg_q.rec_dly <= `RST_RT_REC_DLY;
      cfg_q.kp <= `RST_RT_KP;
      cfg_q.ki <= `RST_RT_KI;
      cfg_q.dec_time <= `RST_RT_DEC_TIME;
    end else if (wr_pend_q) begin
      case (wr_idx_q)
        `IDX_OUT1_SEL: cfg_q.out_sel[0] <= wdat;
        `IDX_OUT2_SEL: cfg_q.out_sel[1] <= wdat;
        `IDX_RELAY_A_SEL: cfg_q.out_sel[2] <= wdat;
        `IDX_RELAY_B_SEL: cfg_q.out_sel[3] <= wdat;
        `IDX_LVL_A_VAL: cfg_q.lvl_val[0] <= wdat;
        `IDX_LVL_A_HYST: cfg_q.lvl_hyst[0] <= wdat;
        `IDX_LVL_B_VAL: cfg_q.lvl_val[1] <= wdat;
        `IDX_LVL_B_HYST: cfg_q.lvl_hyst[1] <= wdat;
        `IDX_RT_MODE: cfg_q.mode <= wdat;
        `IDX_RT_DIS_LVL: cfg_q.dis_lvl <= wdat;
        `IDX_RT_EN_LVL: cfg_q.en_lvl <= wdat;
        `IDX_RT_REC_DLY: cfg_q.rec_dly <= wdat;
        `IDX_RT_KP: cfg_q.kp <= wdat;
        `IDX_RT_KI: cfg_q.ki <= wdat;
        `IDX_RT_DEC_TIME: cfg_q.dec_time <= wdat;
        default: ;
      endcase
    end
  end

  // mode decode; any unlisted code acts as off
  wire mode_hold = (cfg_q.mode == `RT_MODE_HOLD);
  wire mode_stop = (cfg_q.mode == `RT_MODE_STOP);
  wire above_dis = bus_voltage_pct > cfg_q.dis_lvl;
  wire below_en = bus_voltage_pct < cfg_q.en_lvl;
  wire run_rise = run_cmd & ~run_cmd_q;
  wire step_end = (pre_q == 32'(STEP_CYCLES - 1));
  wire rec_done = (rec_cnt_q >= cfg_q.rec_dly);

  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ride_through_pkg::RT_IDLE: begin
        if (!supply_ok && mode_hold)
          state_d = ride_through_pkg::RT_HOLD;
        else if (!supply_ok && mode_stop)
          state_d = ride_through_pkg::RT_DECEL;
      end
      ride_through_pkg::RT_HOLD: begin
        if (supply_ok)
          state_d = ride_through_pkg::RT_RECOVER;
        else if (above_dis)
          state_d = ride_through_pkg::RT_SUSPEND;
      end
      ride_through_pkg::RT_SUSPEND: begin
        if (supply_ok)
          state_d = ride_through_pkg::RT_RECOVER;
        else if (!above_dis)
          state_d = ride_through_pkg::RT_HOLD;
      end
      ride_through_pkg::RT_RECOVER: begin
        if (!supply_ok)
          state_d = ride_through_pkg::RT_HOLD;
        else if (rec_done)
          state_d = ride_through_pkg::RT_IDLE;
      end
      ride_through_pkg::RT_DECEL: begin
        // supply return does not abort the stop
        if (oper_freq == 16'h0000)
          state_d = ride_through_pkg::RT_STOPPED;
      end
      ride_through_pkg::RT_STOPPED: begin
        if (run_rise)
          state_d = ride_through_pkg::RT_IDLE;
      end
      default: state_d = ride_through_pkg::RT_IDLE;
    endcase
    // a mode change drops the sequence at once
    if (!mode_hold && !mode_stop)
      state_d = ride_through_pkg::RT_IDLE;
    else if (mode_hold && (state_q == ride_through_pkg::RT_DECEL ||
             state_q == ride_through_pkg::RT_STOPPED))
      state_d = ride_through_pkg::RT_IDLE;
    else if (mode_stop && (state_q == ride_through_pkg::RT_HOLD ||
             state_q == ride_through_pkg::RT_SUSPEND ||
             state_q == ride_through_pkg::RT_RECOVER))
      state_d = ride_through_pkg::RT_IDLE;
  end

  // sequencer, recovery timer in 0.1 s steps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ride_through_pkg::RT_IDLE;
      pre_q <= 32'h0000_0000;
      rec_cnt_q <= 16'h0000;
      run_cmd_q <= 1'b0;
    end else begin
      state_q <= state_d;
      run_cmd_q <= run_cmd;
      if (state_q != ride_through_pkg::RT_RECOVER) begin
        pre_q <= 32'h0000_0000;
        rec_cnt_q <= 16'h0000;
      end else if (step_end) begin
        pre_q <= 32'h0000_0000;
        rec_cnt_q <= rec_cnt_q + 16'h0001;
      end else begin
        pre_q <= pre_q + 32'h0000_0001;
      end
    end
  end

  // drive commands, all registered; state flags from the next state, gains from the mode alone
  wire nx_decel = (state_d == ride_through_pkg::RT_DECEL);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      regen_hold_q <= 1'b0;
      decel_stop_q <= 1'b0;
      recover_q <= 1'b0;
      uv_en_q <= 1'b1;
      kp_q <= 16'h0000;
      ki_q <= 16'h0000;
      decel_time_q <= 16'h0000;
    end else begin
      regen_hold_q <= (state_d == ride_through_pkg::RT_HOLD);
      decel_stop_q <= nx_decel | (state_d == ride_through_pkg::RT_STOPPED);
      // one-cycle pulse: hand back to the normal accel ramp
      recover_q <= (state_q == ride_through_pkg::RT_RECOVER) &
                   (state_d == ride_through_pkg::RT_IDLE) & supply_ok;
      uv_en_q <= (state_d == ride_through_pkg::RT_IDLE) |
                 (state_d == ride_through_pkg::RT_RECOVER) |
                 (state_d == ride_through_pkg::RT_STOPPED);
      kp_q <= mode_hold ? cfg_q.kp : 16'h0000;
      ki_q <= mode_hold ? cfg_q.ki : 16'h0000;
      decel_time_q <= (nx_decel & below_en) ? cfg_q.dec_time
                                            : normal_decel_time;
    end
  end

  // frequency level detectors, one per channel
  logic [1:0][15:0] lvl_eff, lvl_rel;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lvl
      wire [15:0] hy = (cfg_q.lvl_hyst[g] > `HYST_FULL) ? `HYST_FULL
                                                        : cfg_q.lvl_hyst[g];
      wire [31:0] prod = 32'(lvl_eff[g]) * 32'(hy);
      wire [31:0] lag = prod / 32'd1000;
      // value clamped to the maximum frequency
      assign lvl_eff[g] = (cfg_q.lvl_val[g] > maximum_output_frequency) ?
                          maximum_output_frequency : cfg_q.lvl_val[g];
      // no lag unless decelerating
      assign lvl_rel[g] = decelerating ? lvl_eff[g] - lag[15:0]
                                       : lvl_eff[g];
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
          lvl_q[g] <= 1'b0;
        else if (oper_freq > lvl_eff[g])
          lvl_q[g] <= 1'b1;
        else if (oper_freq < lvl_rel[g])
          lvl_q[g] <= 1'b0;
      end
    end
  endgenerate

  // terminal function routing; codes other than the levels drive low
  generate
    for (g = 0; g < 4; g++) begin : g_term
      wire sel_a = (cfg_q.out_sel[g] == `FUNC_LVL_A);
      wire sel_b = (cfg_q.out_sel[g] == `FUNC_LVL_B);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
          term_q[g] <= 1'b0;
        else
          term_q[g] <= (sel_a & lvl_q[0]) | (sel_b & lvl_q[1]);
      end
    end
  endgenerate

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign regen_hold = regen_hold_q;
  assign rt_gain_kp = kp_q;
  assign rt_gain_ki = ki_q;
  assign decel_to_stop = decel_stop_q;
  assign decel_time = decel_time_q;
  assign recover_accel = recover_q;
  assign uv_trip_enable = uv_en_q;
  assign digital_output_one = term_q[0];
  assign digital_output_two = term_q[1];
  assign relay_a_output = term_q[2];
  assign second_relay_output = term_q[3];

  // checks
  property p_off_no_hold;
    @(posedge hclk) disable iff (!hresetn)
    (cfg_q.mode == `RT_MODE_OFF) |=> !regen_hold_q && uv_en_q;
  endproperty
  a_off_no_hold: assert property (p_off_no_hold)
    else $error("regulation active with ride-through off");

  property p_hold_outage;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == ride_through_pkg::RT_IDLE) && mode_hold && !supply_ok
      |=> regen_hold_q && !uv_en_q;
  endproperty
  a_hold_outage: assert property (p_hold_outage)
    else $error("outage did not start bus hold");

  property p_suspend;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == ride_through_pkg::RT_HOLD) && mode_hold && !supply_ok &&
      above_dis |=> !regen_hold_q ##1 $past(state_q) ==
      ride_through_pkg::RT_SUSPEND;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("bus above disable level did not suspend");

  property p_recover;
    @(posedge hclk) disable iff (!hresetn)
    recover_q |-> $past(state_q) == ride_through_pkg::RT_RECOVER &&
      $past(rec_cnt_q) >= $past(cfg_q.rec_dly);
  endproperty
  a_recover: assert property (p_recover)
    else $error("recovery ended before its delay");

  property p_stop_kept;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == ride_through_pkg::RT_STOPPED) && mode_stop && !run_rise
      |=> decel_stop_q;
  endproperty
  a_stop_kept: assert property (p_stop_kept)
    else $error("stopped drive left stop without run command");

  property p_rt_decel_time;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == ride_through_pkg::RT_DECEL) && mode_stop && below_en &&
      (oper_freq != 16'h0000) |=> decel_time_q == $past(cfg_q.dec_time);
  endproperty
  a_rt_decel_time: assert property (p_rt_decel_time)
    else $error("ride-through decel time not applied");

  property p_gain_mode;
    @(posedge hclk) disable iff (!hresetn)
    !mode_hold |=> kp_q == 16'h0000 && ki_q == 16'h0000;
  endproperty
  a_gain_mode: assert property (p_gain_mode)
    else $error("gains applied outside hold mode");

  property p_lvl_set;
    @(posedge hclk) disable iff (!hresetn)
    (oper_freq > lvl_eff[0]) |=> lvl_q[0];
  endproperty
  a_lvl_set: assert property (p_lvl_set)
    else $error("level A not set above value");

  property p_lvl_rel;
    @(posedge hclk) disable iff (!hresetn)
    decelerating && (32'(oper_freq) * 32'd1000 + 32'(lvl_eff[1]) *
      32'(cfg_q.lvl_hyst[1]) < 32'(lvl_eff[1]) * 32'd1000) |=> !lvl_q[1];
  endproperty
  a_lvl_rel: assert property (p_lvl_rel)
    else $error("level B not released below lag");

  property p_no_lag;
    @(posedge hclk) disable iff (!hresetn)
    !decelerating && (oper_freq < lvl_eff[0]) |=> !lvl_q[0];
  endproperty
  a_no_lag: assert property (p_no_lag)
    else $error("lag applied while not decelerating");

  property p_route;
    @(posedge hclk) disable iff (!hresetn)
    (cfg_q.out_sel[3] == `FUNC_LVL_B) |=> term_q[3] == $past(lvl_q[1]);
  endproperty
  a_route: assert property (p_route)
    else $error("code 16 did not route level B");

endmodule

`default_nettype wire

// ===== drive_stage_model.sv
`timescale 1ns/1ps
`default_nettype none

// motor and power stage seen from the supervision block
module drive_stage_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic outage,
  input wire logic [15:0] sag,
  input wire logic [15:0] target,
  input wire logic run,
  output logic supply_ok,
  output logic [15:0] bus_voltage_pct,
  output logic [15:0] oper_freq,
  output logic decelerating,
  output logic run_cmd
);
  // bus sits at the sag level in an outage whatever the gains are set to;
  // retuning gains after undervoltage trips is the operator's call
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      supply_ok <= 1'b1;
      bus_voltage_pct <= 16'h03E8;
      oper_freq <= 16'h0000;
      decelerating <= 1'b0;
      run_cmd <= 1'b0;
    end else begin
      supply_ok <= !outage;
      bus_voltage_pct <= outage ? sag : 16'h03E8;
      oper_freq <= target;
      run_cmd <= run;
      // direction flag holds while the speed is flat
      if (target < oper_freq) decelerating <= 1'b1;
      else if (target > oper_freq) decelerating <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ===== power_dip_and_freq_level_detect_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ride_through_defines.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  bad_count++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module power_dip_and_freq_level_detect_bench;
  localparam int STEP = 4;
  logic hclk, hresetn, hsel, hwrite, hready;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hresp, supply_ok, decelerating, run_cmd, outage, run;
  logic [15:0] bus_v, oper_freq, sag, target, dec_in;
  logic regen_hold, decel_to_stop, recover_accel, uv_trip_enable;
  logic [15:0] kp, ki, decel_time, hb;
  logic do1, do2, rla, rlb, qa, qb, dec;
  int bad_count, check_count, n, i;
  logic [15:0] pf, f, mfreq;
  logic [13:0] idx[15] = '{`IDX_OUT1_SEL, `IDX_OUT2_SEL,
    `IDX_RELAY_A_SEL, `IDX_RELAY_B_SEL, `IDX_LVL_A_VAL, `IDX_LVL_A_HYST,
    `IDX_LVL_B_VAL, `IDX_LVL_B_HYST, `IDX_RT_MODE, `IDX_RT_DIS_LVL,
    `IDX_RT_EN_LVL, `IDX_RT_REC_DLY, `IDX_RT_KP, `IDX_RT_KI,
    `IDX_RT_DEC_TIME};
  logic [15:0] rst[15] = '{16'h0002, 16'h0002, 16'h0008, 16'h0000,
    16'h01F4, 16'h0000, 16'h01F4, 16'h0000, 16'h0000, 16'h0352,
    16'h0320, 16'h0005, 16'h0032, 16'h001E, 16'h00C8};
  // corner frequencies around level A at 1000 with 50 % lag, and just above level B at 2000
  logic [15:0] corner[11] = '{16'h03E9, 16'h0258, 16'h02BC, 16'h03E9,
    16'h01F5, 16'h01F4, 16'h01F3, 16'h07D1, 16'h05DC, 16'h03E8, 16'h03E9};

  power_dip_and_freq_level_detect #(.STEP_CYCLES(STEP))
  i_power_dip_and_freq_level_detect (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .supply_ok(supply_ok),
    .bus_voltage_pct(bus_v), .oper_freq(oper_freq),
    .maximum_output_frequency(mfreq), .normal_decel_time(dec_in),
    .decelerating(decelerating), .run_cmd(run_cmd),
    .regen_hold(regen_hold), .rt_gain_kp(kp), .rt_gain_ki(ki),
    .decel_to_stop(decel_to_stop), .decel_time(decel_time),
    .recover_accel(recover_accel), .uv_trip_enable(uv_trip_enable),
    .digital_output_one(do1), .digital_output_two(do2),
    .relay_a_output(rla), .second_relay_output(rlb));

  drive_stage_model i_drive_stage_model (.hclk(hclk), .hresetn(hresetn),
    .outage(outage), .sag(sag), .target(target), .run(run),
    .supply_ok(supply_ok), .bus_voltage_pct(bus_v),
    .oper_freq(oper_freq), .decelerating(decelerating),
    .run_cmd(run_cmd));

  always #20 hclk = ~hclk;

  task automatic end_sim();
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // waits for hready at a rising edge, bounded
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (k >= 50) begin
      bad_count++;
      end_sim();
    end
  endtask

  // one single word transfer; the byte address is four times the index
  task automatic ahb(input logic wr, input logic [13:0] ix,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {16'h0000, ix, 2'b00};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  // detector reference: lag counts only while decelerating
  function automatic logic lvl(logic q, logic [15:0] fr, logic [15:0] v,
                               logic [15:0] h, logic dn);
    logic [31:0] lag;
    lag = dn ? (32'(v) * 32'(h)) / 32'd1000 : 32'h0;
    if (fr > v) return 1'b1;
    if ({16'h0000, fr} < {16'h0000, v} - lag) return 1'b0;
    return q;
  endfunction

  initial begin
    wait_rdy();
    repeat (60000) @(posedge hclk);
    bad_count++;
    end_sim();
  end

  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 3'h2; hwdata = 0; outage = 0; sag = 16'h03E8; target = 0;
    run = 1; dec_in = 16'h007B; bad_count = 0; check_count = 0;
    mfreq = 16'h1388;
    void'($urandom(61));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 15; i++) begin
      ahb(1'b0, idx[i], 32'h0);
      `CHK("reset value", {16'h0000, rst[i]}, rd)
    end
    ahb(1'b0, 14'h0123, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    `CHK("okay resp", 1'b0, hresp)
    // route A to one output and one relay, B to the other pair
    ahb(1'b1, `IDX_OUT1_SEL, 32'h000F);
    ahb(1'b1, `IDX_OUT2_SEL, 32'h0010);
    ahb(1'b1, `IDX_RELAY_A_SEL, 32'h000F);
    ahb(1'b1, `IDX_RELAY_B_SEL, 32'h0010);
    ahb(1'b1, `IDX_LVL_A_VAL, 32'h03E8);
    ahb(1'b1, `IDX_LVL_A_HYST, 32'h01F4);
    ahb(1'b1, `IDX_LVL_B_VAL, 32'h07D0);
    hb = 16'($urandom_range(0, 1000));
    ahb(1'b1, `IDX_LVL_B_HYST, {16'h0000, hb});
    ahb(1'b0, `IDX_LVL_B_HYST, 32'h0);
    `CHK("hysteresis b", {16'h0000, hb}, rd)
    qa = 0; qb = 0; dec = 0; pf = 0;
    for (i = 0; i < 51; i++) begin
      f = (i < 11) ? corner[i] : 16'($urandom_range(0, 2500));
      target <= f;
      repeat (4) @(posedge hclk);
      if (f < pf) dec = 1;
      else if (f > pf) dec = 0;
      qa = lvl(qa, f, 16'h03E8, 16'h01F4, dec);
      qb = lvl(qb, f, 16'h07D0, hb, dec);
      pf = f;
      `CHK("out one", qa, do1)
      `CHK("relay a", qa, rla)
      `CHK("out two", qb, do2)
      `CHK("relay b", qb, rlb)
    end
    // outage with handling off
    target <= 16'h0000;
    outage <= 1'b1;
    sag <= 16'h02BC;
    repeat (4) @(posedge hclk);
    `CHK("no regen", 1'b0, regen_hold)
    `CHK("uv allowed", 1'b1, uv_trip_enable)
    outage <= 1'b0;
    ahb(1'b1, `IDX_RT_MODE, 32'h0001);
    outage <= 1'b1;
    repeat (4) @(posedge hclk);
    `CHK("hold", 1'b1, regen_hold)
    `CHK("uv masked", 1'b0, uv_trip_enable)
    `CHK("kp", 16'h0032, kp)
    `CHK("ki", 16'h001E, ki)
    sag <= 16'h0384;
    repeat (4) @(posedge hclk);
    `CHK("suspend", 1'b0, regen_hold)
    outage <= 1'b0;
    n = 0;
    while (recover_accel !== 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    `CHK("recover delay", 1'b1, n >= 5 * STEP && n <= 5 * STEP + 4)
    @(posedge hclk);
    `CHK("recover pulse", 1'b0, recover_accel)
    // stop mode: keeps stopping after the supply returns
    ahb(1'b1, `IDX_RT_MODE, 32'h0002);
    target <= 16'h05DC;
    repeat (4) @(posedge hclk);
    `CHK("normal decel", 16'h007B, decel_time)
    outage <= 1'b1;
    sag <= 16'h02BC;
    repeat (4) @(posedge hclk);
    `CHK("stop decel", 1'b1, decel_to_stop)
    `CHK("dip decel", 16'h00C8, decel_time)
    `CHK("kp off", 16'h0000, kp)
    outage <= 1'b0;
    repeat (30) @(posedge hclk);
    `CHK("still stop", 1'b1, decel_to_stop)
    target <= 16'h0000;
    repeat (4) @(posedge hclk);
    run <= 1'b0;
    repeat (3) @(posedge hclk);
    run <= 1'b1;
    repeat (4) @(posedge hclk);
    `CHK("restart", 1'b0, decel_to_stop)
    // unlisted mode acts as off; levels clamp to the maximum frequency
    ahb(1'b1, `IDX_RT_MODE, 32'h0003);
    mfreq <= 16'h0320;
    target <= 16'h0352;
    outage <= 1'b1;
    sag <= 16'h02BC;
    repeat (4) @(posedge hclk);
    `CHK("odd mode regen", 1'b0, regen_hold)
    `CHK("odd mode uv", 1'b1, uv_trip_enable)
    `CHK("odd mode stop", 1'b0, decel_to_stop)
    `CHK("clamped level a", 1'b1, do1)
    `CHK("clamped level b", 1'b1, do2)
    end_sim();
  end
endmodule

`default_nettype wire
